// ### hdl/iph_pkg.sv
// Shared constants and types for the paged I2C host port, both ends
package iph_pkg;
  // Clock and bit timing
  localparam int CLK_NS         = 40;
  localparam int STD_PERIOD_NS  = 10000;
  localparam int FAST_PERIOD_NS = 2500;
  localparam logic [6:0] QTR_STD  =
    7'((STD_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS));
  localparam logic [6:0] QTR_FAST =
    7'((FAST_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS));
  // Slave address and register-address byte
  localparam logic [4:0] DEV_ADDR_HI = 5'h1C;
  localparam int AW = 7;
  localparam int MEM_DEPTH = 128;
  localparam int AINC_BIT = 7;
  // Pages and device register map
  localparam logic [6:0] PAGE_SEL_ADDR = 7'h7F;
  localparam logic [1:0] PAGE_CTRL = 2'h0;
  localparam logic [1:0] PAGE_RX   = 2'h1;
  localparam logic [1:0] PAGE_TX   = 2'h2;
  localparam logic [1:0] PAGE_TEST = 2'h3;
  localparam logic [6:0] P0_CTRL   = 7'h01;
  localparam logic [6:0] P0_STAT   = 7'h02;
  localparam logic [6:0] P0_MASK   = 7'h03;
  localparam logic [6:0] P0_UNLOCK = 7'h7E;
  localparam logic [7:0] UNLOCK_CODE = 8'hA5;
  localparam logic [1:0] PAGE_RST = 2'h0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  // Controller APB map
  localparam logic [7:0] A_CFG      = 8'h00;
  localparam logic [7:0] A_CMD      = 8'h04;
  localparam logic [7:0] A_STAT     = 8'h08;
  localparam logic [7:0] A_IRQ_STAT = 8'h0C;
  localparam logic [7:0] A_IRQ_CLR  = 8'h10;
  localparam logic [7:0] A_IRQ_EN   = 8'h14;
  localparam logic [7:0] A_RDATA    = 8'h18;
  localparam logic [7:0] A_WDATA    = 8'h1C;
  localparam int CFG_FAST = 0;
  localparam int CMD_READ = 8;
  localparam int CMD_NOREG = 9;
  localparam int CMD_CNT = 10;
  // Device state machine
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_AACK = 4'h3, ST_REG = 4'h2,
    ST_RACK = 4'h6, ST_WR = 4'h7, ST_WACK = 4'h5, ST_RD = 4'h4,
    ST_MACK = 4'hC
  } iph_sst_t;
  // Controller state machine and byte roles
  typedef enum logic [1:0] {
    M_IDLE = 2'h0, M_START = 2'h1, M_BYTE = 2'h3, M_STOP = 2'h2
  } iph_mst_t;
  typedef enum logic [2:0] {
    SG_ADW = 3'h0, SG_REG = 3'h1, SG_WD = 3'h2, SG_ADR = 3'h3, SG_RD = 3'h4
  } iph_stage_t;
endpackage

// ### hdl/iph_if.sv
// Two-wire bus between controller and device, with pull-ups resolved
`timescale 1ns/1ps
interface iph_if;
  logic scl_m_o;
  logic scl_m_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic int_s_o;
  logic int_s_oe_n;
  // Open-drain lines, high when nobody pulls
  wire scl   = scl_m_oe_n ? 1'b1 : scl_m_o;
  wire sda   = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);
  wire int_n = int_s_oe_n ? 1'b1 : int_s_o;
  modport host (output scl_m_o, scl_m_oe_n, sda_m_o, sda_m_oe_n,
                input scl, sda, int_n);
  modport dev  (output sda_s_o, sda_s_oe_n, int_s_o, int_s_oe_n,
                input scl, sda);
endinterface

// ### hdl/iph_host.sv
// I2C bus controller end with APB registers and interrupt
`timescale 1ns/1ps
module iph_host (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  iph_if.host              bus,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);
  import iph_pkg::*;

  function automatic logic [7:0] byte_of(input logic [31:0] w,
                                         input logic [1:0] i);
    byte_of = w[{i, 3'h0} +: 8];
  endfunction

  logic [2:0]  cfg;
  logic [11:0] cmd;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_en;
  logic        busy;
  logic        nack_seen;
  logic [1:0]  sda_s;
  logic [1:0]  int_s;
  iph_mst_t    mst;
  iph_stage_t  stage;
  logic [1:0]  q;
  logic [6:0]  div;
  logic [3:0]  bitn;
  logic [7:0]  tx;
  logic        ackb;
  logic        samp;
  logic [1:0]  left;
  logic [1:0]  idx;
  logic        done_ev;
  logic        nack_ev;

  // APB decode
  wire wr_en  = psel & penable & pwrite;
  wire rd_set = psel & ~penable & ~pwrite;
  wire go     = wr_en & (paddr == A_CMD) & ~busy;
  wire clr_w  = wr_en & (paddr == A_IRQ_CLR);
  wire [2:0] clr = clr_w ? pwdata[2:0] : 3'h0;
  wire [2:0] ev  = {~int_s[1], nack_ev, done_ev};
  wire [31:0] rd_mux =
    (paddr == A_CFG)      ? {29'h0, cfg} :
    (paddr == A_CMD)      ? {20'h0, cmd} :
    (paddr == A_STAT)     ? {30'h0, nack_seen, busy} :
    (paddr == A_IRQ_STAT) ? {29'h0, irq_stat} :
    (paddr == A_IRQ_EN)   ? {29'h0, irq_en} :
    (paddr == A_RDATA)    ? rdata :
    (paddr == A_WDATA)    ? wdata : 32'h0;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Bit timing, quarter bit periods
  wire [6:0] qtr  = cfg[CFG_FAST] ? QTR_FAST : QTR_STD;
  wire       tick = busy & (div == 7'h00);
  wire [6:0] dev_addr = {DEV_ADDR_HI, cfg[2:1]};
  wire rd_stage = (stage == SG_RD);
  wire out_bit  = (bitn[3] | rd_stage) ? (rd_stage & bitn[3] ?
                  (left == 2'h0) : 1'b1) : tx[7];
  wire scl_low  = (mst == M_BYTE || mst == M_START) ? (q == 2'h0 || q == 2'h3)
                  : (mst == M_STOP) ? (q == 2'h0) : 1'b0;
  wire sda_low  = (mst == M_START) ? q[1] : (mst == M_STOP) ? ~q[1] :
                  (mst == M_BYTE) ? ~out_bit : 1'b0;
  assign bus.scl_m_o = 1'b0;
  assign bus.sda_m_o = 1'b0;

  // Pin synchronisers and pin drive
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      sda_s <= 2'h3;
      int_s <= 2'h3;
      bus.scl_m_oe_n <= 1'b1;
      bus.sda_m_oe_n <= 1'b1;
    end
    else
    begin
      sda_s <= {sda_s[0], bus.sda};
      int_s <= {int_s[0], bus.int_n};
      bus.scl_m_oe_n <= ~scl_low;
      bus.sda_m_oe_n <= ~sda_low;
    end

  // Registers, read data and interrupt; an event wins over a clear
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      cfg <= 3'h0;
      cmd <= 12'h000;
      wdata <= 32'h0;
      irq_en <= 3'h0;
      irq_stat <= 3'h0;
      prdata <= 32'h0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == A_CFG) cfg <= pwdata[2:0];
      if (go) cmd <= pwdata[11:0];
      if (wr_en && paddr == A_WDATA) wdata <= pwdata;
      if (wr_en && paddr == A_IRQ_EN) irq_en <= pwdata[2:0];
      irq_stat <= (irq_stat & ~clr) | ev;
      if (rd_set) prdata <= rd_mux;
      irq <= |(irq_stat & irq_en);
    end

  // Transfer sequencer
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      mst <= M_IDLE;
      stage <= SG_ADW;
      busy <= 1'b0;
      q <= 2'h0;
      div <= 7'h00;
      bitn <= 4'h0;
      tx <= 8'h00;
      ackb <= 1'b1;
      samp <= 1'b1;
      left <= 2'h0;
      idx <= 2'h0;
      rdata <= 32'h0;
      nack_seen <= 1'b0;
      done_ev <= 1'b0;
      nack_ev <= 1'b0;
    end
    else
    begin
      done_ev <= 1'b0;
      nack_ev <= 1'b0;
      if (go)
      begin
        busy <= 1'b1;
        mst <= M_START;
        q <= 2'h0;
        div <= qtr - 7'h01;
        nack_seen <= 1'b0;
        stage <= pwdata[CMD_NOREG] ? SG_ADR : SG_ADW;
        left <= pwdata[CMD_CNT +: 2];
        idx <= 2'h0;
      end
      else if (busy && !tick)
        div <= div - 7'h01;
      else if (tick)
      begin
        div <= qtr - 7'h01;
        q <= q + 2'h1;
        // Sample in the middle of the high phase; shift only once SCL is low again,
        // so the driven data bit never moves while SCL is high
        if (mst == M_BYTE && q == 2'h1)
        begin
          if (bitn[3]) ackb <= sda_s[1];
          else samp <= sda_s[1];
        end
        if (q == 2'h3)
        begin
          case (mst)
            M_START:
            begin
              mst <= M_BYTE;
              bitn <= 4'h0;
              tx <= {dev_addr, stage == SG_ADR};
            end
            M_BYTE:
            begin
              bitn <= bitn + 4'h1;
              if (!bitn[3]) tx <= {tx[6:0], samp};
              if (bitn[3])
              begin
                bitn <= 4'h0;
                if (!rd_stage && ackb)
                begin
                  mst <= M_STOP;
                  nack_seen <= 1'b1;
                  nack_ev <= 1'b1;
                end
                else
                  case (stage)
                    SG_ADW:
                    begin
                      stage <= SG_REG;
                      tx <= cmd[7:0];
                    end
                    SG_REG:
                      if (cmd[CMD_READ])
                      begin
                        stage <= SG_ADR;
                        mst <= M_START;
                      end
                      else
                      begin
                        stage <= SG_WD;
                        tx <= byte_of(wdata, idx);
                      end
                    SG_ADR:
                      stage <= SG_RD;
                    default:
                    begin
                      if (rd_stage) rdata[{idx, 3'h0} +: 8] <= tx;
                      if (left == 2'h0)
                        mst <= M_STOP;
                      else
                      begin
                        left <= left - 2'h1;
                        idx <= idx + 2'h1;
                        tx <= byte_of(wdata, idx + 2'h1);
                      end
                    end
                  endcase
              end
            end
            M_STOP:
            begin
              mst <= M_IDLE;
              busy <= 1'b0;
              done_ev <= 1'b1;
            end
            default:
              mst <= M_IDLE;
          endcase
        end
      end
    end
endmodule

// ### hdl/iph_dev.sv
// I2C slave end: paged register and buffer space for an audio transceiver
`timescale 1ns/1ps
// Behaviour
// - Port is I2C while host_port_select high
// - Device is only ever a bus slave
// - Standard and fast bit rates both work
// - Address: fixed upper five, strapped lower two
// - Register byte follows address, with auto-increment
// - Auto-increment steps pointer after each byte
// - Repeated single writes reach scattered locations
// - Current-address read uses the held pointer
// - Random reads set pointer, then read
// - Page select sits at top on every page
// - Pages: control, receive, transmit, test
// - Receive page shows last received block bits
// - Transmit page written by host, reads back
// - Test page locked without unlock code
// - Enabled status bits raise the interrupt
module iph_dev (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  iph_if.dev                         bus,
  input  wire logic                  host_port_select,
  input  wire logic                  strap_addr_bit_low,
  input  wire logic                  strap_addr_bit_high,
  input  wire logic                  rx_we,
  input  wire logic [iph_pkg::AW-1:0] rx_waddr,
  input  wire logic [7:0]            rx_wdata,
  input  wire logic                  rx_block_done,
  input  wire logic [iph_pkg::AW-1:0] tx_raddr,
  output logic      [7:0]            tx_rdata,
  input  wire logic                  tx_block_done,
  output logic      [7:0]            ctrl
);
  import iph_pkg::*;

  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [1:0] sel_s;
  logic [1:0] strap_lo_s;
  logic [1:0] strap_hi_s;
  logic       scl_q;
  logic       sda_q;
  iph_sst_t   state;
  logic [2:0] cnt;
  logic       full;
  logic [7:0] shreg;
  logic       rw;
  logic       nack;
  logic [6:0] ptr;
  logic       ainc;
  logic [1:0] page;
  logic [1:0] stat;
  logic [1:0] mask;
  logic       unlocked;
  logic [7:0] test_reg;
  logic [7:0] rx_mem [0:MEM_DEPTH-1];
  logic [7:0] tx_mem [0:MEM_DEPTH-1];

  // Bus conditions seen on the synchronised lines
  wire scl_rise = scl_s[1] & ~scl_q;
  wire scl_fall = ~scl_s[1] & scl_q;
  wire start_c  = scl_s[1] & scl_q & sda_q & ~sda_s[1];
  wire stop_c   = scl_s[1] & scl_q & ~sda_q & sda_s[1];
  wire [6:0] my_addr = {DEV_ADDR_HI, strap_hi_s[1], strap_lo_s[1]};
  wire in_rx   = (state == ST_ADDR) | (state == ST_REG) | (state == ST_WR);
  wire in_byte = in_rx | (state == ST_RD);
  wire in_ack  = (state == ST_AACK) | (state == ST_RACK) |
                 (state == ST_WACK);
  wire [6:0] next_ptr = ptr + {6'h00, ainc};

  // Host write decode
  wire wr_go   = scl_fall & full & (state == ST_WR);
  wire at_sel  = (ptr == PAGE_SEL_ADDR);
  wire wr_sel  = wr_go & at_sel;
  wire wr_p0   = wr_go & ~at_sel & (page == PAGE_CTRL);
  wire wr_ctrl = wr_p0 & (ptr == P0_CTRL);
  wire wr_stat = wr_p0 & (ptr == P0_STAT);
  wire wr_mask = wr_p0 & (ptr == P0_MASK);
  wire wr_unlk = wr_p0 & (ptr == P0_UNLOCK);
  wire wr_tx   = wr_go & ~at_sel & (page == PAGE_TX);
  wire wr_test = wr_go & ~at_sel & (page == PAGE_TEST) & unlocked;

  // Read selection by page and pointer
  wire [7:0] rd_p0 = (ptr == P0_CTRL) ? ctrl :
                     (ptr == P0_STAT) ? {6'h00, stat} :
                     (ptr == P0_MASK) ? {6'h00, mask} : 8'h00;
  wire [7:0] rd_val =
    at_sel               ? {6'h00, page} :
    (page == PAGE_CTRL)  ? rd_p0 :
    (page == PAGE_RX)    ? rx_mem[ptr] :
    (page == PAGE_TX)    ? tx_mem[ptr] :
    unlocked             ? test_reg : 8'h00;

  // Open-drain data: pull low for acks and zero bits only
  wire drive_low = in_ack | ((state == ST_RD) & ~shreg[7]);
  assign bus.sda_s_o = 1'b0;
  assign bus.int_s_o = 1'b0;

  // Pin synchronisers and pin drive
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      sel_s <= 2'h0;
      strap_lo_s <= 2'h0;
      strap_hi_s <= 2'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bus.sda_s_oe_n <= 1'b1;
      bus.int_s_oe_n <= 1'b1;
    end
    else
    begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
      sel_s <= {sel_s[0], host_port_select};
      strap_lo_s <= {strap_lo_s[0], strap_addr_bit_low};
      strap_hi_s <= {strap_hi_s[0], strap_addr_bit_high};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
      bus.sda_s_oe_n <= ~drive_low;
      bus.int_s_oe_n <= ~|(stat & mask);
    end

  // Slave byte engine
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      state <= ST_IDLE;
      cnt <= 3'h0;
      full <= 1'b0;
      shreg <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      ptr <= 7'h00;
      ainc <= 1'b0;
    end
    else if (!sel_s[1] || stop_c)
      state <= ST_IDLE;
    else if (start_c)
    begin
      state <= ST_ADDR;
      cnt <= 3'h0;
      full <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (in_byte)
      begin
        cnt <= cnt + 3'h1;
        full <= (cnt == 3'h7);
      end
      if (in_rx) shreg <= {shreg[6:0], sda_s[1]};
      if (state == ST_MACK) nack <= sda_s[1];
    end
    else if (scl_fall)
    begin
      full <= 1'b0;
      case (state)
        ST_ADDR:
          if (full)
          begin
            rw <= shreg[0];
            state <= (shreg[7:1] == my_addr) ? ST_AACK : ST_IDLE;
          end
        ST_AACK:
          if (rw)
          begin
            shreg <= rd_val;
            state <= ST_RD;
          end
          else
            state <= ST_REG;
        ST_REG:
          if (full)
          begin
            ptr <= shreg[6:0];
            ainc <= shreg[AINC_BIT];
            state <= ST_RACK;
          end
        ST_RACK:
          state <= ST_WR;
        ST_WACK:
          state <= ST_WR;
        ST_WR:
          if (full)
          begin
            ptr <= next_ptr;
            state <= ST_WACK;
          end
        ST_RD:
          if (full)
          begin
            ptr <= next_ptr;
            state <= ST_MACK;
          end
          else
            shreg <= {shreg[6:0], 1'b1};
        ST_MACK:
          if (nack)
            state <= ST_IDLE;
          else
          begin
            shreg <= rd_val;
            state <= ST_RD;
          end
        default:
          state <= ST_IDLE;
      endcase
    end

  // Page 0 registers, page select and unlock; an event wins over a clear
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      page <= PAGE_RST;
      ctrl <= CTRL_RST;
      mask <= MASK_RST;
      stat <= 2'h0;
      unlocked <= 1'b0;
      test_reg <= 8'h00;
    end
    else
    begin
      if (wr_sel) page <= shreg[1:0];
      if (wr_ctrl) ctrl <= shreg;
      if (wr_mask) mask <= shreg[1:0];
      if (wr_unlk) unlocked <= (shreg == UNLOCK_CODE);
      if (wr_test) test_reg <= shreg;
      stat <= (stat & ~(wr_stat ? shreg[1:0] : 2'h0)) |
              {tx_block_done, rx_block_done};
    end

  // Channel buffers: receive side filled by the audio receiver
  always_ff @(posedge clk)
  begin
    if (rx_we) rx_mem[rx_waddr] <= rx_wdata;
    if (wr_tx) tx_mem[ptr] <= shreg;
    tx_rdata <= tx_mem[tx_raddr];
  end
endmodule

// ### verif/iph_link_props.sv
// Link-level assertions watching both ends of the two-wire bus
`timescale 1ns/1ps
module iph_link_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sda_m_oe_n,
  input wire logic sda_s_oe_n,
  input wire logic int_s_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Device never moves SDA while SCL is high
  chk_dev_stable_high: assert property (
    scl && $past(scl) |-> $stable(sda_s_oe_n))
    else $error("device SDA moved while SCL high");
  // Device changes SDA only well inside the SCL low phase
  chk_dev_moves_low: assert property (
    $changed(sda_s_oe_n) |-> !scl && $past(!scl, 2))
    else $error("device SDA changed near SCL edge");
  // Only the controller makes a start
  chk_start_by_host: assert property (
    scl && $past(scl) && $fell(sda) |-> !sda_m_oe_n && sda_s_oe_n)
    else $error("start not made by controller");
  // Only the controller makes a stop
  chk_stop_by_host: assert property (
    scl && $past(scl) && $rose(sda) |-> $rose(sda_m_oe_n))
    else $error("stop not made by controller");
  // SCL high and low phases respect the fastest bit rate
  chk_scl_high_min: assert property (
    $rose(scl) |=> scl [*8])
    else $error("SCL high phase too short");
  chk_scl_low_min: assert property (
    $fell(scl) |=> !scl [*8])
    else $error("SCL low phase too short");
  chk_start_hold: assert property (
    scl && $past(scl) && $fell(sda) |=> scl [*8])
    else $error("start hold too short");
  // Device interrupt is a level, not a glitch
  chk_int_steady: assert property (
    $fell(int_s_oe_n) |=> !int_s_oe_n [*3])
    else $error("device interrupt glitched");
endmodule

// ### verif/tb_i2c_paged_register_host_port.sv
// Bench: controller and device joined over the two-wire link
`timescale 1ns/1ps
module tb_i2c_paged_register_host_port;
  import iph_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        host_port_select = 1'b1;
  logic        strap_lo = 1'b1;
  logic        strap_hi = 1'b0;
  logic        rx_we = 1'b0;
  logic [6:0]  rx_waddr = 7'h00;
  logic [7:0]  rx_wdata = 8'h00;
  logic        rx_block_done = 1'b0;
  logic        tx_block_done = 1'b0;
  logic [6:0]  tx_raddr = 7'h00;
  logic [7:0]  tx_rdata;
  logic [7:0]  ctrl;
  logic [31:0] q;
  int          fails = 0;
  int          checks = 0;
  iph_if bus_if ();
  iph_host iph_host_i (.clk(clk), .sys_rst(sys_rst), .bus(bus_if),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  iph_dev iph_dev_i (.clk(clk), .sys_rst(sys_rst), .bus(bus_if),
    .host_port_select(host_port_select), .strap_addr_bit_low(strap_lo),
    .strap_addr_bit_high(strap_hi), .rx_we(rx_we), .rx_waddr(rx_waddr),
    .rx_wdata(rx_wdata), .rx_block_done(rx_block_done),
    .tx_raddr(tx_raddr), .tx_rdata(tx_rdata),
    .tx_block_done(tx_block_done), .ctrl(ctrl));
  iph_link_props iph_link_props_i (.clk(clk), .sys_rst(sys_rst),
    .sda_m_oe_n(bus_if.sda_m_oe_n), .sda_s_oe_n(bus_if.sda_s_oe_n),
    .int_s_oe_n(bus_if.int_s_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));
  // 25 MHz clock
  always #20 clk = ~clk;
  task automatic wrap_up;
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read a register until bit b equals v, bounded
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    logic [31:0] r;
    int          n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0, r);
      n++;
    end
    while (r[b] !== v && n < 30000);
    chk({31'h0, r[b]}, {31'h0, v});
  endtask
  // Launch a bus command, wait for idle, check NACK and read data
  task automatic xfer(input logic [11:0] cmd, input logic [31:0] wd,
                      input logic [31:0] exp, input logic nack);
    logic [31:0] r;
    logic [31:0] m;
    apb(1'b1, A_WDATA, wd, r);
    apb(1'b1, A_CMD, {20'h0, cmd}, r);
    poll(A_STAT, 0, 1'b0);
    apb(1'b0, A_STAT, 32'h0, r);
    chk({31'h0, r[1]}, {31'h0, nack});
    m = 32'hFFFFFFFF >> (8 * (3 - int'(cmd[11:10])));
    if (cmd[8])
    begin
      apb(1'b0, A_RDATA, 32'h0, r);
      chk(r & m, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer({4'h0, a}, {24'h0, d}, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer({4'h1, a}, 32'h0, {24'h0, e}, 1'b0);
  endtask
  // Watchdog
  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, A_CFG, 32'h2, q);
    wr(8'h01, 8'h5C);
    chk({24'h0, ctrl}, 32'h5C);
    apb(1'b1, A_CFG, 32'h3, q);
    rd(8'h01, 8'h5C);
    host_port_select <= 1'b0;
    repeat (4) @(posedge clk);
    xfer(12'h001, 32'h77, 32'h0, 1'b1);
    host_port_select <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h01, 8'h5C);
    wr(8'h7F, 8'h02);
    xfer(12'hC90, 32'hA1B2C3D4, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      tx_raddr <= 7'(16 + i);
      @(posedge clk);
      @(negedge clk);
      chk({24'h0, tx_rdata}, (32'hA1B2C3D4 >> (8 * i)) & 32'hFF);
    end
    xfer(12'h990, 32'h0, 32'hB2C3D4, 1'b0);
    xfer(12'h300, 32'h0, 32'hA1, 1'b0);
    xfer(12'h511, 32'h0, 32'hC3C3, 1'b0);
    xfer(12'h300, 32'h0, 32'hC3, 1'b0);
    apb(1'b1, A_CFG, 32'h5, q);
    xfer(12'h010, 32'h11, 32'h0, 1'b1);
    // Restrap the device to the address now targeted
    strap_lo <= 1'b0;
    strap_hi <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h7F, 8'h02);
    strap_lo <= 1'b1;
    strap_hi <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, A_CFG, 32'h3, q);
    @(posedge clk);
    rx_we <= 1'b1;
    rx_waddr <= 7'h05;
    rx_wdata <= 8'h5A;
    @(posedge clk);
    rx_we <= 1'b0;
    wr(8'h7F, 8'h01);
    wr(8'h05, 8'h00);
    rd(8'h05, 8'h5A);
    wr(8'h7F, 8'h03);
    wr(8'h10, 8'h33);
    rd(8'h10, 8'h00);
    wr(8'h7F, 8'h00);
    wr(8'h7E, 8'hA5);
    wr(8'h7F, 8'h03);
    wr(8'h10, 8'h33);
    rd(8'h10, 8'h33);
    wr(8'h7F, 8'h00);
    rd(8'h7F, 8'h00);
    wr(8'h03, 8'h01);
    apb(1'b1, A_IRQ_EN, 32'h0, q);
    @(posedge clk);
    rx_block_done <= 1'b1;
    tx_block_done <= 1'b1;
    @(posedge clk);
    rx_block_done <= 1'b0;
    tx_block_done <= 1'b0;
    poll(A_IRQ_STAT, 2, 1'b1);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, A_IRQ_EN, 32'h4, q);
    repeat (4) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(8'h02, 8'h03);
    wr(8'h02, 8'h03);
    apb(1'b1, A_IRQ_CLR, 32'h4, q);
    poll(A_IRQ_STAT, 2, 1'b0);
    repeat (4) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    wrap_up();
  end
endmodule
